//--- common/sepp_pkg.sv
// shared constants for the serial nonvolatile programming port
package sepp_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // command and response word layout
  localparam int WORD_BITS = 32;
  localparam int SEL_DATA_BIT = 29;
  localparam int SEL_CODE_BIT = 28;
  localparam int DIR_READ_BIT = 24;
  localparam int ADDR_MSB = 17;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  // memory sizes in bytes
  localparam int DATA_MEM_BYTES = 64;
  localparam int CODE_MEM_BYTES = 1024;
  localparam int INIT_REG_BYTES = 8;
  // timing, in ns and derived clock counts
  localparam int WRITE_TIME_NS = 10000;
  localparam int WRITE_CYC = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_NS = 850;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_NS = 1000;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ENTRY_NS = 2000;
  localparam int ENTRY_CYC = (ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // programmer register map (byte offsets)
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_RESP = 4'h8;
  localparam logic [3:0] REG_CTRL = 4'hc;
  localparam int STAT_MODE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_VALID_BIT = 3;
  localparam int CTRL_ENTER_BIT = 0;
  localparam logic [31:0] RESP_RESET = 32'h0;

  // true when a command word asks for a read
  function automatic logic sepp_is_read(input logic [WORD_BITS-1:0] w);
    return w[DIR_READ_BIT];
  endfunction : sepp_is_read
endpackage : sepp_pkg

//--- common/sepp_link_if.sv
`timescale 1ns/1ns
// four-wire programming link plus the auxiliary pin
interface sepp_link_if;
  logic load_hv;
  logic load_hi;
  logic sclk;
  logic cmd;
  logic rsp;
  logic rsp_oe;
  logic aux_out;
  logic aux_oe;
  logic rsp_level;
  logic aux_level;
  // undriven pins float high through the pull-ups
  assign rsp_level = rsp_oe ? rsp : 1'b1;
  assign aux_level = aux_oe ? aux_out : 1'b1;
  modport dev (input load_hv, input load_hi, input sclk, input cmd, output rsp, output rsp_oe);
  modport prog (output load_hv, output load_hi, output sclk, output cmd, output aux_out, output aux_oe,
                input rsp_level);
endinterface : sepp_link_if

//--- core/sepp_dev.sv
`timescale 1ns/1ns
// Overview of operation
// - four wires: strobe, command, response, clock
// - supervoltage enters mode, then 5V before shifting
// - 32-bit commands, bit 31 first
// - previous response shifts out during command
// - programmer samples response 850ns after rise
// - first response after entry is meaningless
// - strobe 0V then two clocks execute
// - reads return strobe to 5V before next
// - write pulls response low by second edge
// - finished write sets write-done flag
// - programmer waits for write-done before 5V
// - bit 29 selects data memory
// - bit 28 code memory, else init registers
// - bit 24 one reads, zero writes
// - address in bits 17-8, echoed back
// - data in bits 7-0 both ways
// - read sequence checked by echoed address
// - memory addresses map as in normal use
// - auxiliary pin left open or high
module sepp_dev (
  input wire logic clk_in,
  input wire logic rst_in,
  sepp_link_if.dev link,
  input wire logic [1:0] nv_sel_in,
  input wire logic [sepp_pkg::ADDR_W-1:0] nv_addr_in,
  output logic [sepp_pkg::DATA_W-1:0] nv_data_out,
  output logic prog_mode_out,
  output logic write_busy_out,
  output logic write_done_out
);
  localparam int IN_HV = 3;
  localparam int IN_HI = 2;
  localparam int IN_CLK = 1;
  localparam int IN_CMD = 0;

  typedef enum logic [2:0] {D_OFF, D_ENTER, D_SHIFT, D_EXEC, D_BUSY, D_HOLD} sepp_dstate_t;
  typedef struct packed {
    sepp_dstate_t state;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
    logic [31:0] cmd_sr;
    logic [31:0] resp_sr;
    logic [5:0] bits;
    logic [1:0] pulses;
    logic [sepp_pkg::CNT_W-1:0] busy_cnt;
    logic rsp;
    logic done;
    logic mode;
  } sepp_dev_state_t;

  sepp_dev_state_t r;
  sepp_dev_state_t next_r;
  logic [sepp_pkg::DATA_W-1:0] data_mem [sepp_pkg::DATA_MEM_BYTES];
  logic [sepp_pkg::DATA_W-1:0] code_mem [sepp_pkg::CODE_MEM_BYTES];
  logic [sepp_pkg::DATA_W-1:0] init_mem [sepp_pkg::INIT_REG_BYTES];
  logic mem_we;
  logic [3:0] filt_now;
  logic clk_rise;
  logic [sepp_pkg::ADDR_W-1:0] cmd_addr;
  logic [sepp_pkg::DATA_W-1:0] cmd_data;

  // one byte from the space chosen by the two select bits
  function automatic logic [sepp_pkg::DATA_W-1:0] sepp_pick(input logic sel_data, input logic sel_code,
                                                          input logic [sepp_pkg::ADDR_W-1:0] a);
    logic [sepp_pkg::DATA_W-1:0] v;
    v = init_mem[a[2:0]];
    if (sel_data) begin
      v = data_mem[a[5:0]];
    end else if (sel_code) begin
      v = code_mem[a];
    end
    return v;
  endfunction : sepp_pick

  assign cmd_addr = r.cmd_sr[sepp_pkg::ADDR_MSB:sepp_pkg::ADDR_LSB];
  assign cmd_data = r.cmd_sr[sepp_pkg::DATA_MSB:0];

  // glitch filter: a pin change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      filt_now[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.filt[i];
    end
    // command sampled on filtered clock rise
    clk_rise = filt_now[IN_CLK] & ~r.filt[IN_CLK];
  end

  // protocol engine
  always_comb begin
    next_r = r;
    mem_we = 1'b0;
    next_r.s1 = {link.load_hv, link.load_hi, link.sclk, link.cmd};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.filt = filt_now;
    unique case (r.state)
      D_OFF: begin
        if (filt_now[IN_HV]) begin
          next_r.state = D_ENTER;
          next_r.mode = 1'b1;
        end
      end
      D_ENTER: begin
        // nothing defined to send yet, zeros go out
        if (!filt_now[IN_HV] && filt_now[IN_HI]) begin
          next_r.state = D_SHIFT;
          next_r.resp_sr = '0;
          next_r.rsp = 1'b0;
          next_r.bits = '0;
        end
      end
      D_SHIFT: begin
        if (!filt_now[IN_HI]) begin
          // a short command is dropped, not executed
          next_r.state = (r.bits == 6'(sepp_pkg::WORD_BITS)) ? D_EXEC : D_HOLD;
          next_r.pulses = '0;
        end else if (clk_rise) begin
          next_r.cmd_sr = {r.cmd_sr[30:0], filt_now[IN_CMD]};
          // previous response advances after each rise
          // bit n goes out on rise n, so a sample 850ns later sees it
          next_r.resp_sr = {r.resp_sr[30:0], 1'b0};
          next_r.rsp = r.resp_sr[31];
          next_r.bits = r.bits + 6'h01;
        end
      end
      D_EXEC: begin
        // two clock pulses with strobe low execute
        if (clk_rise) begin
          next_r.pulses = r.pulses + 2'h1;
          if (r.pulses == 2'h0 && !sepp_pkg::sepp_is_read(r.cmd_sr)) begin
            // ready low already at first rise
            next_r.rsp = 1'b0;
            next_r.done = 1'b0;
          end
          if (r.pulses == 2'h1) begin
            // echo address; top bits left zero
            next_r.resp_sr = {14'h0, cmd_addr, cmd_data};
            if (sepp_pkg::sepp_is_read(r.cmd_sr)) begin
              next_r.resp_sr[sepp_pkg::DATA_MSB:0] = sepp_pick(r.cmd_sr[sepp_pkg::SEL_DATA_BIT],
                                                              r.cmd_sr[sepp_pkg::SEL_CODE_BIT], cmd_addr);
              next_r.state = D_HOLD;
            end else begin
              mem_we = 1'b1;
              next_r.busy_cnt = sepp_pkg::CNT_W'(sepp_pkg::WRITE_CYC);
              next_r.state = D_BUSY;
            end
          end
        end
      end
      D_BUSY: begin
        next_r.busy_cnt = r.busy_cnt - 16'h0001;
        // write finished, flag and ready go high
        if (r.busy_cnt == 16'h0001) begin
          next_r.done = 1'b1;
          next_r.rsp = 1'b1;
          next_r.state = D_HOLD;
        end
      end
      D_HOLD: begin
        // strobe back at 5V starts the next command
        if (filt_now[IN_HI] && !filt_now[IN_HV]) begin
          next_r.state = D_SHIFT;
          next_r.rsp = r.resp_sr[31];
          next_r.bits = '0;
        end
      end
    endcase
    // a fresh supervoltage restarts the entry sequence
    if (filt_now[IN_HV] && r.state != D_OFF) begin
      next_r.state = D_ENTER;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // memory arrays; no reset, contents are nonvolatile
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      // same addressing as the normal read port
      if (r.cmd_sr[sepp_pkg::SEL_DATA_BIT]) begin
        data_mem[cmd_addr[5:0]] <= cmd_data;
      end else if (r.cmd_sr[sepp_pkg::SEL_CODE_BIT]) begin
        code_mem[cmd_addr] <= cmd_data;
      end else begin
        init_mem[cmd_addr[2:0]] <= cmd_data;
      end
    end
  end

  // normal-operation read port, one cycle latency
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      nv_data_out <= 8'h00;
    end else begin
      nv_data_out <= sepp_pick(nv_sel_in[1], nv_sel_in[0], nv_addr_in);
    end
  end

  // response pin driven only in programming mode
  assign link.rsp = r.rsp;
  assign link.rsp_oe = r.mode;
  assign prog_mode_out = r.mode;
  assign write_busy_out = (r.state == D_BUSY);
  assign write_done_out = r.done;
endmodule : sepp_dev

//--- core/sepp_prog.sv
`timescale 1ns/1ns
// external programmer end: drives strobe, clock and command
module sepp_prog (
  input wire logic clk_in,
  input wire logic rst_in,
  sepp_link_if.prog link,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out
);
  localparam logic [15:0] HALF_LAST = 16'(sepp_pkg::SCLK_HALF_CYC - 1);
  localparam logic [15:0] ACCESS_AT = 16'(sepp_pkg::ACCESS_CYC);
  localparam logic [15:0] ENTRY_LAST = 16'(sepp_pkg::ENTRY_CYC - 1);

  typedef enum logic [2:0] {P_OFF, P_HV, P_READY, P_LOW, P_HIGH, P_XLOW, P_XHIGH, P_WAIT} sepp_pstate_t;
  typedef struct packed {
    sepp_pstate_t state;
    logic s1;
    logic s2;
    logic s3;
    logic rsp;
    logic [15:0] cnt;
    logic [5:0] bits;
    logic pulses;
    logic [31:0] tx;
    logic rd_cmd;
    logic [31:0] shin;
    logic [31:0] resp;
    logic valid;
    logic first;
    logic mode;
    logic done;
    logic load_hv;
    logic load_hi;
    logic sclk;
    logic [31:0] rdata;
  } sepp_prog_state_t;

  sepp_prog_state_t r;
  sepp_prog_state_t next_r;
  logic busy;

  assign busy = (r.state != P_READY) && (r.state != P_OFF);

  always_comb begin
    next_r = r;
    // three-stage synchroniser and agreement filter on the response pin
    next_r.s1 = link.rsp_level;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.s2 == r.s3) begin
      next_r.rsp = r.s3;
    end
    next_r.cnt = r.cnt + 16'h0001;
    // register reads, data valid the cycle after the strobe
    next_r.rdata = 32'h0;
    if (rd_in) begin
      unique case (addr_in)
        sepp_pkg::REG_STAT: begin
          next_r.rdata[sepp_pkg::STAT_MODE_BIT] = r.mode;
          next_r.rdata[sepp_pkg::STAT_BUSY_BIT] = busy;
          next_r.rdata[sepp_pkg::STAT_DONE_BIT] = r.done;
          next_r.rdata[sepp_pkg::STAT_VALID_BIT] = r.valid;
        end
        sepp_pkg::REG_RESP: next_r.rdata = r.resp;
        default: next_r.rdata = 32'h0;
      endcase
    end
    unique case (r.state)
      P_OFF, P_READY: begin
        if (wr_in && addr_in == sepp_pkg::REG_CTRL && wdata_in[sepp_pkg::CTRL_ENTER_BIT]) begin
          next_r.state = P_HV;
          next_r.load_hv = 1'b1;
          next_r.load_hi = 1'b0;
          next_r.cnt = '0;
        end else if (wr_in && addr_in == sepp_pkg::REG_CMD && r.state == P_READY) begin
          next_r.tx = wdata_in & 32'h3103_ffff;
          next_r.rd_cmd = sepp_pkg::sepp_is_read(wdata_in);
          next_r.done = 1'b0;
          next_r.bits = '0;
          next_r.cnt = '0;
          next_r.state = P_LOW;
        end
      end
      P_HV: begin
        // back to 5V before any bit shifts
        if (r.cnt == ENTRY_LAST) begin
          next_r.load_hv = 1'b0;
          next_r.load_hi = 1'b1;
          next_r.mode = 1'b1;
          next_r.first = 1'b1;
          next_r.state = P_READY;
        end
      end
      P_LOW: begin
        // command bit set up during the low half
        if (r.cnt == HALF_LAST) begin
          next_r.sclk = 1'b1;
          next_r.cnt = '0;
          next_r.state = P_HIGH;
        end
      end
      P_HIGH: begin
        // response sampled 850ns after the rise
        if (r.cnt == ACCESS_AT) begin
          next_r.shin = {r.shin[30:0], r.rsp};
        end
        if (r.cnt == HALF_LAST) begin
          next_r.sclk = 1'b0;
          next_r.cnt = '0;
          next_r.tx = {r.tx[30:0], 1'b0};
          next_r.bits = r.bits + 6'h01;
          next_r.state = P_LOW;
          // after 32 bits the strobe drops to 0V
          if (r.bits == 6'(sepp_pkg::WORD_BITS - 1)) begin
            next_r.load_hi = 1'b0;
            next_r.pulses = 1'b0;
            next_r.state = P_XLOW;
          end
        end
      end
      P_XLOW: begin
        if (r.cnt == HALF_LAST) begin
          next_r.sclk = 1'b1;
          next_r.cnt = '0;
          next_r.state = P_XHIGH;
        end
      end
      P_XHIGH: begin
        if (r.cnt == HALF_LAST) begin
          next_r.sclk = 1'b0;
          next_r.cnt = '0;
          next_r.pulses = 1'b1;
          next_r.state = P_XLOW;
          if (r.pulses) begin
            // the word after entry is thrown away
            // response kept for address check by software
            if (!r.first) begin
              next_r.resp = r.shin;
              next_r.valid = 1'b1;
            end
            next_r.first = 1'b0;
            // a read goes straight back to 5V
            next_r.state = r.rd_cmd ? P_READY : P_WAIT;
            next_r.load_hi = r.rd_cmd;
          end
        end
      end
      P_WAIT: begin
        // hold 0V until ready shows high again
        if (r.rsp) begin
          next_r.done = 1'b1;
          next_r.load_hi = 1'b1;
          next_r.state = P_READY;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // strobe, clock and command driven from registers
  assign link.load_hv = r.load_hv;
  assign link.load_hi = r.load_hi;
  assign link.sclk = r.sclk;
  assign link.cmd = r.tx[31];
  assign link.aux_out = 1'b1;
  assign link.aux_oe = 1'b1;
  assign rdata_out = r.rdata;
endmodule : sepp_prog

//--- dv/sepp_link_props.sv
`timescale 1ns/1ns
// protocol checker that sees only the link wires
module sepp_link_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic load_hv,
  input wire logic load_hi,
  input wire logic sclk,
  input wire logic cmd,
  input wire logic rsp_oe,
  input wire logic rsp_level,
  input wire logic aux_level
);
  logic [5:0] bit_cnt;
  logic [1:0] exec_cnt;
  logic [7:0] since_edge;
  logic [31:0] shreg;

  // command image and phase counts rebuilt from the wires
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bit_cnt <= 6'h0;
      exec_cnt <= 2'h0;
      since_edge <= 8'h0;
      shreg <= 32'h0;
    end else begin
      bit_cnt <= !load_hi ? 6'h0 : bit_cnt + {5'h0, $rose(sclk)};
      exec_cnt <= (load_hv || load_hi) ? 2'h0 : exec_cnt + {1'b0, $rose(sclk) && exec_cnt != 2'h3};
      // saturates so a long idle cannot wrap back into the window
      since_edge <= ($rose(sclk) || $rose(load_hi)) ? 8'h0 : since_edge + {7'h0, since_edge != 8'hff};
      if (load_hi && $rose(sclk)) begin
        shreg <= {shreg[30:0], cmd};
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // execute phase and the start of the next command
  sequence s_frame_end;
    $fell(load_hi) && !load_hv;
  endsequence
  sequence s_write_second_rise;
    $rose(sclk) && exec_cnt == 2'h1 && !load_hi && !load_hv && !shreg[24];
  endsequence
  sequence s_next_after_write;
    $rose(load_hi) && exec_cnt == 2'h2 && !shreg[24];
  endsequence

  AST_AUX_HIGH: assert property (aux_level)
    else $error("auxiliary pin not high");
  AST_NO_SHIFT_HV: assert property ($rose(sclk) |-> !load_hv)
    else $error("clock pulse at supervoltage");
  AST_BIT_COUNT: assert property (s_frame_end |-> bit_cnt == 6'h20)
    else $error("frame not 32 bits");
  AST_EXEC_PULSES: assert property ($rose(load_hi) |-> exec_cnt == 2'h0 || exec_cnt == 2'h2)
    else $error("not two execute pulses");
  AST_READY_LOW: assert property (s_write_second_rise |-> !rsp_level)
    else $error("ready not low by second rise");
  AST_DONE_BEFORE_NEXT: assert property (s_next_after_write |-> rsp_level)
    else $error("next command before write done");
  AST_CMD_STABLE: assert property (load_hi && sclk && $past(sclk) |-> $stable(cmd))
    else $error("command bit moved while clock high");
  AST_RSP_AFTER_RISE: assert property (load_hi && $past(load_hi) && $changed(rsp_level) |-> since_edge <= 8'h0c)
    else $error("response moved away from clock rise");
  AST_RSP_DRIVEN: assert property (load_hi && $past(load_hi, 8) |-> rsp_oe)
    else $error("response pin not driven in mode");
endmodule : sepp_link_props

//--- dv/tb_top.sv
`timescale 1ns/1ns
// bench joining programmer and device across the link
module tb_top;
  typedef struct packed {
    logic [31:0] cmd;
    logic [31:0] resp;
  } sepp_row_t;
  logic clk_in;
  logic rst_in;
  logic [3:0] addr_in;
  logic [31:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [31:0] rdata_out;
  logic [1:0] nv_sel_in;
  logic [sepp_pkg::ADDR_W-1:0] nv_addr_in;
  logic [sepp_pkg::DATA_W-1:0] nv_data_out;
  logic prog_mode_out;
  logic write_busy_out;
  logic write_done_out;
  logic [31:0] rd_val;
  int fail_count;
  int n_compared;
  sepp_row_t rows [8];

  sepp_link_if link_bus ();

  sepp_prog u_sepp_prog (.clk_in(clk_in), .rst_in(rst_in), .link(link_bus), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
  sepp_dev u_sepp_dev (.clk_in(clk_in), .rst_in(rst_in), .link(link_bus), .nv_sel_in(nv_sel_in),
    .nv_addr_in(nv_addr_in), .nv_data_out(nv_data_out), .prog_mode_out(prog_mode_out),
    .write_busy_out(write_busy_out), .write_done_out(write_done_out));
  sepp_link_props props (.clk_in(clk_in), .rst_in(rst_in), .load_hv(link_bus.load_hv),
    .load_hi(link_bus.load_hi), .sclk(link_bus.sclk), .cmd(link_bus.cmd), .rsp_oe(link_bus.rsp_oe),
    .rsp_level(link_bus.rsp_level), .aux_level(link_bus.aux_level));

  // free-running system clock
  initial begin
    clk_in = 1'b0;
    forever #(sepp_pkg::CLK_PERIOD_NS / 2) clk_in = ~clk_in;
  end

  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : reg_wr

  // read data exist only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : reg_rd

  // bounded poll until the programmer is in mode and idle
  task automatic wait_idle();
    for (int i = 0; i < 12000; i++) begin
      reg_rd(sepp_pkg::REG_STAT, rd_val);
      if (rd_val[sepp_pkg::STAT_BUSY_BIT] === 1'b0 && rd_val[sepp_pkg::STAT_MODE_BIT] === 1'b1) break;
    end
  endtask : wait_idle

  task automatic nv_peek(input logic [1:0] sel, input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    nv_sel_in <= sel;
    nv_addr_in <= a;
    repeat (2) @(posedge clk_in);
    check("memory port", {24'h0, exp}, {24'h0, nv_data_out});
  endtask : nv_peek

  // hang guard, about a third above the expected run length
  initial begin
    repeat (95000) @(posedge clk_in);
    fail_count++;
    finish_test();
  end

  initial begin
    fail_count = 0;
    n_compared = 0;
    rst_in = 1'b1;
    addr_in = 4'h0;
    wdata_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    nv_sel_in = 2'h0;
    nv_addr_in = 10'h0;
    // command, response due one command later
    rows[0] = '{32'h2000_05a5, 32'h0};
    rows[1] = '{32'h1003_ff3c, 32'h0000_05a5};
    rows[2] = '{32'h0000_0281, 32'h0003_ff3c};
    rows[3] = '{32'h2100_0500, 32'h0000_0281};
    rows[4] = '{32'h1103_ff00, 32'h0000_05a5};
    rows[5] = '{32'h0100_0200, 32'h0003_ff3c};
    // reserved bits set and both selects: data memory wins
    rows[6] = '{32'hfffc_0500, 32'h0000_0281};
    rows[7] = '{32'h0100_0200, 32'h0000_05a5};
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    check("idle wires", 32'h1, {27'h0, link_bus.load_hv, link_bus.load_hi, link_bus.sclk, link_bus.rsp_oe,
      link_bus.aux_level});
    reg_rd(4'h2, rd_val);
    check("unmapped read", 32'h0, rd_val);
    // a command outside programming mode is dropped
    reg_wr(sepp_pkg::REG_CMD, rows[0].cmd);
    reg_rd(sepp_pkg::REG_STAT, rd_val);
    check("status before entry", 32'h0, rd_val);
    reg_wr(sepp_pkg::REG_CTRL, 32'h1);
    wait_idle();
    check("mode flag", 32'h1, {31'h0, prog_mode_out});
    for (int i = 0; i < 8; i++) begin
      reg_wr(sepp_pkg::REG_CMD, rows[i].cmd);
      wait_idle();
      // done only after a write, response valid from the second command on
      check("status", {28'h0, (i > 0), !rows[i].cmd[24], 2'b01}, rd_val);
      if (rows[i].cmd[24] === 1'b0) begin
        check("write done", 32'h1, {31'h0, write_done_out});
        check("write busy", 32'h0, {31'h0, write_busy_out});
      end
      reg_rd(sepp_pkg::REG_RESP, rd_val);
      // the first word after entry carries nothing
      if (i > 0) begin
        check("response word", rows[i].resp, rd_val);
      end else begin
        check("first response", sepp_pkg::RESP_RESET, rd_val);
      end
    end
    nv_peek(2'b10, 10'h005, 8'ha5);
    nv_peek(2'b01, 10'h3ff, 8'h3c);
    nv_peek(2'b00, 10'h002, 8'h81);
    check("clock at rest", 32'h0, {31'h0, link_bus.sclk});
    // second reset in mid-run leaves mode
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    reg_rd(sepp_pkg::REG_STAT, rd_val);
    check("status after reset", 32'h0, {rd_val[31:1], prog_mode_out});
    finish_test();
  end
endmodule : tb_top
